// *** core/fdcr_pkg.sv ***
// shared constants for the floppy drive control register block
package fdcr_pkg;
    // register addresses on the 16-bit io address
    localparam logic [15:0] FDCR_ADDR_DOC = 16'h03f2;
    localparam logic [15:0] FDCR_ADDR_TAPE = 16'h03f3;
    localparam logic [15:0] FDCR_ADDR_RATE = 16'h03f4;
    localparam logic [15:0] FDCR_ADDR_CFG = 16'h03f7;
    // drive_output_control field positions
    localparam int FDCR_DOC_NUM_LSB = 0;
    localparam int FDCR_DOC_RST_BIT = 2;
    localparam int FDCR_DOC_DMA_BIT = 3;
    localparam int FDCR_DOC_MOT0_BIT = 4;
    localparam int FDCR_DOC_MOT1_BIT = 5;
    // rate_and_precomp_select field positions
    localparam int FDCR_RATE_CODE_LSB = 0;
    localparam int FDCR_RATE_PRE_LSB = 2;
    localparam int FDCR_RATE_ZERO_BIT = 5;
    localparam int FDCR_RATE_PD_BIT = 6;
    localparam int FDCR_RATE_SWR_BIT = 7;
    // reset values
    localparam logic [7:0] FDCR_DOC_RESET = 8'h00;
    localparam logic [1:0] FDCR_TAPE_RESET = 2'h0;
    localparam logic [7:0] FDCR_RATE_RESET = 8'h02;
    // least soft reset length, ns, and its cycle count at 20 MHz
    localparam int FDCR_SWR_MIN_NS = 100;
    localparam int FDCR_CLK_NS = 50;
    localparam int FDCR_SWR_CYCLES = (FDCR_SWR_MIN_NS + FDCR_CLK_NS - 1)
                                     / FDCR_CLK_NS;
    // system modes
    typedef enum logic [2:0] {
        FDCR_MODE_AT = 3'h1,
        FDCR_MODE_M30 = 3'h2,
        FDCR_MODE_ENH = 3'h4
    } fdcr_mode_t;
endpackage

// *** core/fdcr_decode.sv ***
// drive select and motor decode, normal or swapped
`timescale 1ns/1ps
`default_nettype none
module fdcr_decode
    import fdcr_pkg::*;
(
    input wire logic [1:0] drive_num,
    input wire logic motor_on_bit_0,
    input wire logic motor_on_bit_1,
    input wire logic swap_drives,
    output logic drive_sel_0_low,
    output logic drive_sel_1_low,
    output logic motor_out_0_low,
    output logic motor_out_1_low
);
    wire logic sel0_n;
    wire logic sel1_n;
    assign sel0_n = !(drive_num == 2'h0 && motor_on_bit_0);
    assign sel1_n = !(drive_num == 2'h1 && motor_on_bit_1);
    // swap exchanges selects and motors together
    assign drive_sel_0_low = swap_drives ? sel1_n : sel0_n;
    assign drive_sel_1_low = swap_drives ? sel0_n : sel1_n;
    assign motor_out_0_low = swap_drives ? !motor_on_bit_1 : !motor_on_bit_0;
    assign motor_out_1_low = swap_drives ? !motor_on_bit_0 : !motor_on_bit_1;
endmodule // fdcr_decode
`default_nettype wire

// *** core/fdcr_regs.sv ***
// floppy drive control, tape assignment and rate select registers
// How it works
// - drive number bits pick one select
// - reset bit low holds controller reset
// - soft reset keeps rate, config, other bits
// - soft reset lasts at least 100ns
// - drive control writable always, survives soft reset
// - dma gate enables dma pins and interrupt
// - dma gate reads zero after reset
// - enhanced mode keeps dma, interrupt enabled
// - bits 4 and 5 drive motors
// - bits 6 and 7 drive nothing
// - tape bits assign drives one to three
// - tape upper bits float, survive soft reset
// - normal decode selects by number and motor
// - motors inverted, swap exchanges both pairs
// - enhanced mode two tape read layout
// - drive type picked from config byte
// - rate select is write only
// - last write of rate or config wins
// - hardware reset loads rate with 02h
// - rate select bit layout
// - rate soft reset bit self clears
// - power down until reset or access
`timescale 1ns/1ps
`default_nettype none
module fdcr_regs
    import fdcr_pkg::*;
#(
    parameter int SWR_CYCLES = FDCR_SWR_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic [7:0] io_rdata_oe,
    input wire fdcr_mode_t sys_mode,
    input wire logic enhanced_floppy_mode_two,
    input wire logic swap_drives,
    input wire logic [7:0] drive_type_config_byte,
    input wire logic [1:0] boot_drive,
    input wire logic data_access,
    input wire logic dma_req_core,
    output logic soft_reset_low,
    output logic dma_irq_gate,
    output logic dma_req_out,
    output logic dma_req_oe,
    output logic drive_sel_0_low,
    output logic drive_sel_1_low,
    output logic motor_out_0_low,
    output logic motor_out_1_low,
    output logic [1:0] rate_code,
    output logic [2:0] write_shift,
    output logic power_down
);
    initial begin
        if (SWR_CYCLES < 1 || SWR_CYCLES > 255) begin
            $error("fdcr_regs: SWR_CYCLES out of range");
        end
    end

    logic [7:0] doc_q;
    logic [1:0] tape_q;
    logic [7:0] rate_q;
    logic [1:0] eff_rate_q;
    logic [7:0] swr_cnt_q;
    logic [7:0] swr_cnt_d;
    logic pd_q;
    logic srst_q;
    logic gate_q;
    logic req_q;
    logic req_oe_q;
    logic [7:0] rd_q;
    logic [7:0] rd_oe_q;
    logic ds0_q;
    logic ds1_q;
    logic mt0_q;
    logic mt1_q;
    wire logic ds0_w;
    wire logic ds1_w;
    wire logic mt0_w;
    wire logic mt1_w;

    // address decode
    wire logic hit_doc = io_addr == FDCR_ADDR_DOC;
    wire logic hit_tape = io_addr == FDCR_ADDR_TAPE;
    wire logic hit_rate = io_addr == FDCR_ADDR_RATE;
    wire logic hit_cfg = io_addr == FDCR_ADDR_CFG;
    wire logic wr_doc = io_wr && hit_doc;
    wire logic wr_tape = io_wr && hit_tape;
    wire logic wr_rate = io_wr && hit_rate;
    wire logic wr_cfg = io_wr && hit_cfg;
    wire logic enh = sys_mode == FDCR_MODE_ENH;

    // drive type field chosen by the drive number
    function automatic logic [1:0] type_pick(input logic [7:0] cfg,
                                             input logic [1:0] num);
        type_pick = cfg[{num, 1'b0} +: 2];
    endfunction

    // drive control accepts writes at any time
    // no soft reset term touches this register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            doc_q <= FDCR_DOC_RESET;
        end else if (wr_doc) begin
            doc_q <= io_wdata;
        end
    end

    // tape bits have only the hardware reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tape_q <= FDCR_TAPE_RESET;
        end else if (wr_tape) begin
            tape_q <= io_wdata[1:0];
        end
    end

    // only the hardware reset loads 02h
    // bit 5 is stored as zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rate_q <= FDCR_RATE_RESET;
        end else if (wr_rate) begin
            rate_q <= {io_wdata[7:6], 1'b0, io_wdata[4:0]};
        end else if (rate_q[FDCR_RATE_SWR_BIT] && swr_cnt_q != 8'h00) begin
            // self clear once the stretch counter is loaded
            // the standing bit reloads the counter every cycle, so a
            // wait for any lower count would keep the reset forever
            rate_q[FDCR_RATE_SWR_BIT] <= 1'b0;
        end
    end

    // last writer of rate or config sets the rate
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            eff_rate_q <= FDCR_RATE_RESET[1:0];
        end else if (wr_rate) begin
            eff_rate_q <= io_wdata[FDCR_RATE_CODE_LSB +: 2];
        end else if (wr_cfg) begin
            eff_rate_q <= io_wdata[1:0];
        end
    end

    // stretch any soft reset request to the least length
    wire logic swr_req = !doc_q[FDCR_DOC_RST_BIT]
                         || rate_q[FDCR_RATE_SWR_BIT];
    always_comb begin
        swr_cnt_d = swr_cnt_q;
        if (swr_req) begin
            swr_cnt_d = 8'(SWR_CYCLES);
        end else if (swr_cnt_q != 8'h00) begin
            swr_cnt_d = swr_cnt_q - 8'h01;
        end
    end
    // counter cleared at reset; soft reset then comes from the reset bit, which resets low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            swr_cnt_q <= 8'h00;
        end else begin
            swr_cnt_q <= swr_cnt_d;
        end
    end

    // power down until soft reset or data access
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pd_q <= 1'b0;
        end else if (wr_rate && io_wdata[FDCR_RATE_PD_BIT]) begin
            pd_q <= 1'b1;
        end else if (swr_req || data_access) begin
            pd_q <= 1'b0;
        end
    end

    // reset stays active while the bit is low
    wire logic srst_d = swr_req || swr_cnt_q != 8'h00;
    // gate enables dma and irq in at and m30 modes
    // enhanced mode keeps them enabled through reset
    wire logic gate_d = enh || doc_q[FDCR_DOC_DMA_BIT];

    // one select at a time from the number bits
    // bits 4 and 5 feed the motors; 6, 7 unused
    // swap choice is a plain input
    fdcr_decode u_decode (
        .drive_num(doc_q[FDCR_DOC_NUM_LSB +: 2]),
        .motor_on_bit_0(doc_q[FDCR_DOC_MOT0_BIT]),
        .motor_on_bit_1(doc_q[FDCR_DOC_MOT1_BIT]),
        .swap_drives(swap_drives),
        .drive_sel_0_low(ds0_w),
        .drive_sel_1_low(ds1_w),
        .motor_out_0_low(mt0_w),
        .motor_out_1_low(mt1_w)
    );

    // read mux; rate select is write only so reads there float
    // no read path for rate select
    // upper tape bits float in normal mode
    wire logic [7:0] tape_rd = enhanced_floppy_mode_two ?
        {2'h0, type_pick(drive_type_config_byte, doc_q[1:0]),
         boot_drive, tape_q} : {6'h00, tape_q};
    wire logic [7:0] tape_oe = enhanced_floppy_mode_two ? 8'hff : 8'h03;
    // reading back the gate shows the stored drive control bit, zero after reset or after a write that clears it
    wire logic [7:0] rd_d = hit_doc ? doc_q : hit_tape ? tape_rd : 8'h00;
    wire logic [7:0] oe_d = !io_rd ? 8'h00 : hit_doc ? 8'hff :
                            hit_tape ? tape_oe : 8'h00;

    // output flops: one cycle behind the decode
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            srst_q <= 1'b1;
            gate_q <= 1'b0;
            req_q <= 1'b0;
            req_oe_q <= 1'b0;
            rd_q <= 8'h00;
            rd_oe_q <= 8'h00;
            ds0_q <= 1'b1;
            ds1_q <= 1'b1;
            mt0_q <= 1'b1;
            mt1_q <= 1'b1;
        end else begin
            srst_q <= srst_d;
            gate_q <= gate_d;
            req_q <= dma_req_core && gate_d;
            req_oe_q <= gate_d;
            rd_q <= rd_d;
            rd_oe_q <= oe_d;
            ds0_q <= ds0_w;
            ds1_q <= ds1_w;
            mt0_q <= mt0_w;
            mt1_q <= mt1_w;
        end
    end

    assign soft_reset_low = !srst_q;
    assign dma_irq_gate = gate_q;
    assign dma_req_out = req_q;
    assign dma_req_oe = req_oe_q;
    assign io_rdata = rd_q;
    assign io_rdata_oe = rd_oe_q;
    assign drive_sel_0_low = ds0_q;
    assign drive_sel_1_low = ds1_q;
    assign motor_out_0_low = mt0_q;
    assign motor_out_1_low = mt1_q;
    assign rate_code = eff_rate_q;
    assign write_shift = rate_q[FDCR_RATE_PRE_LSB +: 3];
    assign power_down = pd_q;

    // checks
    a_sel_onehot: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(ds0_q == 1'b0 && ds1_q == 1'b0))
        else $error("two drive selects active");
    a_rst_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !doc_q[FDCR_DOC_RST_BIT] |=> !soft_reset_low)
        else $error("soft reset not held");
    a_rst_length: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(soft_reset_low) |=> !soft_reset_low)
        else $error("soft reset too short");
    a_doc_keep: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !wr_doc |=> $stable(doc_q))
        else $error("drive control changed without write");
    a_gate_enh: assert property (@(posedge clk_sys) disable iff (!reset_n)
        enh |=> dma_irq_gate)
        else $error("enhanced mode gate dropped");
    a_motor_map: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !swap_drives && !wr_doc |=> motor_out_0_low == !doc_q[4])
        else $error("motor output mismatch");
    a_rate_last: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_cfg && !wr_rate |=> rate_code == $past(io_wdata[1:0]))
        else $error("rate not from last write");
    a_swr_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_rate && io_wdata[7] && doc_q[2] |-> ##[1:6] !rate_q[7])
        else $error("rate soft reset did not clear");
    a_pd_wake: assert property (@(posedge clk_sys) disable iff (!reset_n)
        power_down && data_access && !wr_rate |=> !power_down)
        else $error("power down not left on access");
    a_gate_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !enh && !doc_q[FDCR_DOC_DMA_BIT] |=> !dma_req_oe && !dma_irq_gate)
        else $error("dma request not floated with gate clear");
    a_tape_float: assert property (@(posedge clk_sys) disable iff (!reset_n)
        io_rd && hit_tape && !enhanced_floppy_mode_two |=> io_rdata_oe == 8'h03)
        else $error("upper tape bits driven in normal mode");
    a_sel_decode: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !swap_drives && !wr_doc && doc_q[1:0] == 2'h0
        && doc_q[FDCR_DOC_MOT0_BIT] |=> !drive_sel_0_low)
        else $error("drive 0 select not asserted");
    c_drive0: cover property (@(posedge clk_sys) wr_doc && io_wdata == 8'h1c);
    c_drive1: cover property (@(posedge clk_sys) wr_doc && io_wdata == 8'h2d);
    c_swr: cover property (@(posedge clk_sys) $rose(soft_reset_low));
    c_swap: cover property (@(posedge clk_sys) swap_drives && !ds0_q);
    c_enh_two: cover property (@(posedge clk_sys)
        io_rd && hit_tape && enhanced_floppy_mode_two);
endmodule // fdcr_regs
`default_nettype wire

// *** verif/fdcr_drive_model.sv ***
// floppy drive model on the far side of the select and motor lines
`timescale 1ns/1ps
`default_nettype none
module fdcr_drive_model (
    input wire logic drive_sel_0_low,
    input wire logic drive_sel_1_low,
    input wire logic motor_out_0_low,
    input wire logic motor_out_1_low,
    output logic [1:0] sel_count,
    output logic [1:0] spin_mask
);
    // count of selects seen on the cable; two would be a bus fight
    assign sel_count = {1'b0, ~drive_sel_0_low} + {1'b0, ~drive_sel_1_low};
    // motor lines are active low at the drive
    assign spin_mask = {~motor_out_1_low, ~motor_out_0_low};
endmodule // fdcr_drive_model
`default_nettype wire

// *** verif/fdcr_regs_tb_top.sv ***
// self-checking bench for the floppy drive control registers
`timescale 1ns/1ps
`default_nettype none
module fdcr_regs_tb_top;
    import fdcr_pkg::*;
    localparam int SWR = 2;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata, io_rdata_oe;
    fdcr_mode_t sys_mode = FDCR_MODE_AT;
    logic enhanced_floppy_mode_two = 1'b0;
    logic swap_drives = 1'b0;
    logic [7:0] drive_type_config_byte = 8'h1b;
    logic [1:0] boot_drive = 2'h2;
    logic data_access = 1'b0;
    logic dma_req_core = 1'b1;
    logic soft_reset_low, dma_irq_gate, dma_req_out, dma_req_oe;
    logic drive_sel_0_low, drive_sel_1_low, motor_out_0_low, motor_out_1_low;
    logic [1:0] rate_code, sel_count, spin_mask;
    logic [2:0] write_shift;
    logic power_down;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int low_cnt = 0;
    int low_base = 0;
    wire [3:0] pins;
    assign pins = {drive_sel_1_low, drive_sel_0_low, motor_out_1_low,
                   motor_out_0_low};

    fdcr_regs #(.SWR_CYCLES(SWR)) fdcr_regs_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
        .sys_mode(sys_mode),
        .enhanced_floppy_mode_two(enhanced_floppy_mode_two),
        .swap_drives(swap_drives),
        .drive_type_config_byte(drive_type_config_byte),
        .boot_drive(boot_drive), .data_access(data_access),
        .dma_req_core(dma_req_core), .soft_reset_low(soft_reset_low),
        .dma_irq_gate(dma_irq_gate), .dma_req_out(dma_req_out),
        .dma_req_oe(dma_req_oe), .drive_sel_0_low(drive_sel_0_low),
        .drive_sel_1_low(drive_sel_1_low), .motor_out_0_low(motor_out_0_low),
        .motor_out_1_low(motor_out_1_low), .rate_code(rate_code),
        .write_shift(write_shift), .power_down(power_down));

    fdcr_drive_model fdcr_drive_model_inst (
        .drive_sel_0_low(drive_sel_0_low), .drive_sel_1_low(drive_sel_1_low),
        .motor_out_0_low(motor_out_0_low), .motor_out_1_low(motor_out_1_low),
        .sel_count(sel_count), .spin_mask(spin_mask));

    // 50 ns clock
    always #25 clk_sys = ~clk_sys;

    // timeout and soft reset length watch; whole run is well under 3000
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (!soft_reset_low) begin
            low_cnt <= low_cnt + 1;
        end
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // strobe stays high so back-to-back writes never toggle it in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        io_rd = 1'b0;
        io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge clk_sys);
    endtask

    task automatic wt(input int n);
        io_wr = 1'b0;
        io_rd = 1'b0;
        repeat (n) @(negedge clk_sys);
    endtask

    // floated bits are masked by the enable so they never count
    // read data stands one cycle only, so it is taken at the next negedge;
    // the strobe stays high and the next task lowers it
    task automatic rd(input logic [15:0] a, input logic [7:0] e,
                      input logic [7:0] oe);
        io_wr = 1'b0;
        io_rd = 1'b1;
        io_addr = a;
        @(negedge clk_sys);
        chk(io_rdata & io_rdata_oe, e);
        chk(io_rdata_oe, oe);
    endtask

    task automatic hw_reset();
        reset_n = 1'b0;
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
        chk(soft_reset_low, 1'b0);
        chk(dma_irq_gate, 1'b0);
        chk({rate_code, write_shift, power_down}, 8'h20);
        chk(pins, 4'hf);
        rd(FDCR_ADDR_DOC, 8'h00, 8'hff);
    endtask

    initial begin
        hw_reset();
        // activation values in both legacy modes
        for (int m = 0; m < 2; m++) begin
            sys_mode = m ? FDCR_MODE_M30 : FDCR_MODE_AT;
            wr(FDCR_ADDR_DOC, 8'h1c);
            wt(6);
            chk(pins, 4'ha);
            chk(sel_count, 2'h1);
            chk(soft_reset_low, 1'b1);
            chk({dma_irq_gate, dma_req_oe, dma_req_out}, 3'h7);
            wr(FDCR_ADDR_DOC, 8'h2d);
            wt(2);
            chk(pins, 4'h5);
            chk(spin_mask, 2'h2);
            wr(FDCR_ADDR_DOC, 8'h24);
            wt(2);
            chk(pins, 4'hd);
            chk({dma_irq_gate, dma_req_oe}, 2'h0);
        end
        swap_drives = 1'b1;
        wr(FDCR_ADDR_DOC, 8'h2d);
        wt(2);
        chk(pins, 4'ha);
        swap_drives = 1'b0;
        wr(FDCR_ADDR_DOC, 8'hc4);
        wt(2);
        chk(pins, 4'hf);
        sys_mode = FDCR_MODE_ENH;
        wt(2);
        chk(dma_irq_gate, 1'b1);
        sys_mode = FDCR_MODE_AT;
        // every tape code, upper bits written high but floated on read
        for (int t = 0; t < 4; t++) begin
            wr(FDCR_ADDR_TAPE, {6'h3f, t[1:0]});
            rd(FDCR_ADDR_TAPE, {6'h00, t[1:0]}, 8'h03);
        end
        enhanced_floppy_mode_two = 1'b1;
        for (int n = 0; n < 4; n++) begin
            wr(FDCR_ADDR_DOC, {6'h01, n[1:0]});
            rd(FDCR_ADDR_TAPE, {2'h0, ~n[1:0], 4'hb}, 8'hff);
        end
        enhanced_floppy_mode_two = 1'b0;
        wr(FDCR_ADDR_RATE, 8'h1d);
        wt(2);
        chk({rate_code, write_shift}, 5'h0f);
        rd(FDCR_ADDR_RATE, 8'h00, 8'h00);
        wr(FDCR_ADDR_CFG, 8'h03);
        wt(2);
        chk(rate_code, 2'h3);
        wr(FDCR_ADDR_RATE, 8'h5d);
        wt(2);
        chk(power_down, 1'b1);
        // reset bit held low stays in reset, then a quick toggle
        wr(FDCR_ADDR_DOC, 8'h18);
        wt(10);
        chk(soft_reset_low, 1'b0);
        wr(FDCR_ADDR_DOC, 8'h1c);
        wt(8);
        low_base = low_cnt;
        wr(FDCR_ADDR_DOC, 8'h18);
        wr(FDCR_ADDR_DOC, 8'h1c);
        wt(8);
        chk((low_cnt - low_base) >= SWR, 1'b1);
        chk(soft_reset_low, 1'b1);
        chk(power_down, 1'b0);
        chk({rate_code, write_shift}, 5'h0f);
        rd(FDCR_ADDR_DOC, 8'h1c, 8'hff);
        rd(FDCR_ADDR_TAPE, 8'h03, 8'h03);
        wr(FDCR_ADDR_RATE, 8'h5d);
        wt(2);
        data_access = 1'b1;
        wt(1);
        data_access = 1'b0;
        wt(2);
        chk(power_down, 1'b0);
        low_base = low_cnt;
        wr(FDCR_ADDR_RATE, 8'h9d);
        wt(8);
        chk(low_cnt != low_base, 1'b1);
        chk(soft_reset_low, 1'b1);
        wr(16'h03f5, 8'hff);
        rd(16'h03f0, 8'h00, 8'h00);
        rd(FDCR_ADDR_DOC, 8'h1c, 8'hff);
        hw_reset();
        print_verdict();
    end
endmodule // fdcr_regs_tb_top
`default_nettype wire
